// ### rtl/twbbl_core.sv
// two-wire bus bit layer: master and slave on open-drain lines
// What this block does
// - one clock pulse per data bit
// - data changes only with clock low
// - start and stop: data moves, clock high
// - master opens with start, closes with stop
// - master makes the serial clock
// - busy from start to stop; no new start
// - master restarts by repeated start
// - repeated start acts as start; busy until stop
// - lines only pulled low or released
// - line low when any party pulls it
// - high means released by all parties
// - master or slave, transmitting or receiving
// - 7-bit slave address, 128 addresses
// - programmable own address; optional general call
// - own address match wakes the device
// - serial clock up to 400 kHz
// - inputs synchronised and spike filtered
// - address packet: seven address bits, read/write, ack
// - receiver acks by pulling data low in ninth clock
// - most significant bit first
// - all-zero address is general call
`timescale 1ns/10ps
module twbbl_core
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // bus pins, open drain
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_n,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // master command
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [1:0] cmd_code,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_ack,
  // master result
  output logic            m_done,
  output logic [7:0]      m_rd_data,
  output logic            m_ack_rcvd,
  output logic            m_arb_lost,
  // slave setup
  input  wire logic       slv_enable,
  input  wire logic [6:0] slv_own_addr,
  input  wire logic       slv_gc_enable,
  input  wire logic       slv_ack_en,
  input  wire logic [7:0] slv_tx_data,
  // slave events
  output logic            slv_addressed,
  output logic            slv_read,
  output logic            slv_gc,
  output logic            slv_wake,
  output logic [7:0]      slv_rx_data,
  output logic            slv_rx_valid,
  output logic            slv_tx_load,
  // bus state
  output logic            bus_busy,
  output logic            start_seen,
  output logic            stop_seen
);

  // ==========================================================
  // input conditioning
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] scl_cnt_reg;
  logic [1:0] sda_cnt_reg;
  logic       scl_f_reg;
  logic       sda_f_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;

  // new level must outlast the spike width
  function automatic logic [2:0] filt_next(input logic raw, input logic cur,
                                           input logic [1:0] cnt);
    if (raw == cur)
      filt_next = {cur, 2'h0};
    else if (cnt == twbbl_pkg::SPIKE_CYC)
      filt_next = {raw, 2'h0};
    else
      filt_next = {cur, cnt + 2'h1};
  endfunction

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scl_f_reg   <= 1'b1;
      sda_f_reg   <= 1'b1;
      scl_cnt_reg <= 2'h0;
      sda_cnt_reg <= 2'h0;
      scl_d_reg   <= 1'b1;
      sda_d_reg   <= 1'b1;
    end
    else
    begin
      {scl_f_reg, scl_cnt_reg} <= filt_next(scl_sync_reg[1], scl_f_reg, scl_cnt_reg);
      {sda_f_reg, sda_cnt_reg} <= filt_next(sda_sync_reg[1], sda_f_reg, sda_cnt_reg);
      scl_d_reg <= scl_f_reg;
      sda_d_reg <= sda_f_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_f_reg & ~scl_d_reg;
  assign scl_fall  = ~scl_f_reg & scl_d_reg;
  assign start_det = scl_f_reg & scl_d_reg & sda_d_reg & ~sda_f_reg;
  assign stop_det  = scl_f_reg & scl_d_reg & ~sda_d_reg & sda_f_reg;

  // ==========================================================
  // bus busy tracking
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bus_busy   <= 1'b0;
      start_seen <= 1'b0;
      stop_seen  <= 1'b0;
    end
    else
    begin
      start_seen <= start_det;
      stop_seen  <= stop_det;
      if (start_det)
        bus_busy <= 1'b1;
      else if (stop_det)
        bus_busy <= 1'b0;
    end
  end

  // ==========================================================
  // master engine
  twbbl_pkg::twbbl_mstate_t m_state_reg;
  logic [4:0] tmr_reg;
  logic [3:0] m_cnt_reg;
  logic [7:0] m_sh_reg;
  logic       m_rd_reg;
  logic       m_ack_reg;
  logic       m_scl_low_reg;
  logic       m_sda_low_reg;
  logic       tmr_done;
  logic       take;

  assign tmr_done  = (tmr_reg == 5'h00);
  // a fresh start waits for an idle bus; a held bus takes any command
  assign cmd_ready = ((m_state_reg == twbbl_pkg::M_IDLE) & ~bus_busy)
                   | (m_state_reg == twbbl_pkg::M_HOLD);
  assign take      = cmd_valid & cmd_ready;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      m_state_reg   <= twbbl_pkg::M_IDLE;
      tmr_reg       <= 5'h00;
      m_cnt_reg     <= 4'h0;
      m_sh_reg      <= 8'h00;
      m_rd_reg      <= 1'b0;
      m_ack_reg     <= 1'b0;
      m_scl_low_reg <= 1'b0;
      m_sda_low_reg <= 1'b0;
      m_done        <= 1'b0;
      m_rd_data     <= 8'h00;
      m_ack_rcvd    <= 1'b0;
      m_arb_lost    <= 1'b0;
    end
    else
    begin
      m_done     <= 1'b0;
      m_arb_lost <= 1'b0;
      if (!tmr_done)
        tmr_reg <= tmr_reg - 5'h01;
      case (m_state_reg)
        twbbl_pkg::M_IDLE:
        begin
          m_scl_low_reg <= 1'b0;
          m_sda_low_reg <= 1'b0;
          if (take)
          begin
            if (cmd_code == twbbl_pkg::CMD_START)
            begin
              m_sda_low_reg <= 1'b1;
              tmr_reg       <= twbbl_pkg::HALF_CYC;
              m_state_reg   <= twbbl_pkg::M_START;
            end
            else
              m_done <= 1'b1;
          end
        end
        twbbl_pkg::M_START:
        begin
          if (tmr_done)
          begin
            m_scl_low_reg <= 1'b1;
            m_done        <= 1'b1;
            m_state_reg   <= twbbl_pkg::M_HOLD;
          end
        end
        twbbl_pkg::M_HOLD:
        begin
          // clock held low between commands
          if (take)
          begin
            tmr_reg   <= twbbl_pkg::HALF_CYC;
            m_cnt_reg <= 4'h0;
            case (cmd_code)
              twbbl_pkg::CMD_WRITE:
              begin
                m_sh_reg    <= cmd_data;
                m_rd_reg    <= 1'b0;
                m_state_reg <= twbbl_pkg::M_LOW;
              end
              twbbl_pkg::CMD_READ:
              begin
                m_rd_reg    <= 1'b1;
                m_ack_reg   <= cmd_ack;
                m_state_reg <= twbbl_pkg::M_LOW;
              end
              twbbl_pkg::CMD_STOP:
              begin
                m_sda_low_reg <= 1'b1;
                m_state_reg   <= twbbl_pkg::M_STOP_LO;
              end
              default:
              begin
                m_sda_low_reg <= 1'b0;
                m_state_reg   <= twbbl_pkg::M_RS_LO;
              end
            endcase
          end
        end
        twbbl_pkg::M_LOW:
        begin
          // data set one cycle into the low phase
          if (tmr_reg == twbbl_pkg::HALF_CYC)
          begin
            if (m_cnt_reg < twbbl_pkg::LAST_DATA_BIT)
              m_sda_low_reg <= ~m_rd_reg & ~m_sh_reg[7];
            else
              m_sda_low_reg <= m_rd_reg & m_ack_reg;
          end
          if (tmr_done)
          begin
            m_scl_low_reg <= 1'b0;
            tmr_reg       <= twbbl_pkg::HALF_CYC;
            m_state_reg   <= twbbl_pkg::M_HIGH;
          end
        end
        twbbl_pkg::M_HIGH:
        begin
          if (!scl_f_reg)
            tmr_reg <= twbbl_pkg::HALF_CYC;
          else if (tmr_done)
          begin
            m_scl_low_reg <= 1'b1;
            if (!m_sda_low_reg && !sda_f_reg && !m_rd_reg
                && m_cnt_reg < twbbl_pkg::LAST_DATA_BIT)
            begin
              // arbitration lost: release both
              m_scl_low_reg <= 1'b0;
              m_sda_low_reg <= 1'b0;
              m_arb_lost    <= 1'b1;
              m_done        <= 1'b1;
              m_state_reg   <= twbbl_pkg::M_IDLE;
            end
            else if (m_cnt_reg == twbbl_pkg::LAST_DATA_BIT)
            begin
              m_ack_rcvd  <= ~sda_f_reg;
              m_rd_data   <= m_sh_reg;
              m_done      <= 1'b1;
              m_state_reg <= twbbl_pkg::M_HOLD;
            end
            else
            begin
              m_sh_reg    <= {m_sh_reg[6:0], sda_f_reg};
              m_cnt_reg   <= m_cnt_reg + 4'h1;
              tmr_reg     <= twbbl_pkg::HALF_CYC;
              m_state_reg <= twbbl_pkg::M_LOW;
            end
          end
        end
        twbbl_pkg::M_STOP_LO:
        begin
          if (tmr_done)
          begin
            m_scl_low_reg <= 1'b0;
            tmr_reg       <= twbbl_pkg::HALF_CYC;
            m_state_reg   <= twbbl_pkg::M_STOP_HI;
          end
        end
        twbbl_pkg::M_STOP_HI:
        begin
          if (!scl_f_reg)
            tmr_reg <= twbbl_pkg::HALF_CYC;
          else if (tmr_done)
          begin
            m_sda_low_reg <= 1'b0;
            tmr_reg       <= twbbl_pkg::HALF_CYC;
            m_state_reg   <= twbbl_pkg::M_STOP_END;
          end
        end
        twbbl_pkg::M_STOP_END:
        begin
          if (tmr_done)
          begin
            m_done      <= 1'b1;
            m_state_reg <= twbbl_pkg::M_IDLE;
          end
        end
        twbbl_pkg::M_RS_LO:
        begin
          if (tmr_done)
          begin
            m_scl_low_reg <= 1'b0;
            tmr_reg       <= twbbl_pkg::HALF_CYC;
            m_state_reg   <= twbbl_pkg::M_RS_HI;
          end
        end
        twbbl_pkg::M_RS_HI:
        begin
          if (!scl_f_reg)
            tmr_reg <= twbbl_pkg::HALF_CYC;
          else if (tmr_done)
          begin
            m_sda_low_reg <= 1'b1;
            tmr_reg       <= twbbl_pkg::HALF_CYC;
            m_state_reg   <= twbbl_pkg::M_START;
          end
        end
        default:
          m_state_reg <= twbbl_pkg::M_IDLE;
      endcase
    end
  end

  // ==========================================================
  // slave engine
  twbbl_pkg::twbbl_sstate_t s_state_reg;
  logic [3:0] s_cnt_reg;
  logic [7:0] s_sh_reg;
  logic [7:0] s_tx_reg;
  logic       s_sda_low_reg;
  logic       s_mack_reg;
  logic       m_active;
  logic       addr_hit;
  logic       gc_hit;

  assign m_active = (m_state_reg != twbbl_pkg::M_IDLE);
  assign gc_hit   = slv_gc_enable & (s_sh_reg[7:1] == twbbl_pkg::GC_ADDR)
                  & ~s_sh_reg[0];
  assign addr_hit = (s_sh_reg[7:1] == slv_own_addr) | gc_hit;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_state_reg   <= twbbl_pkg::S_IDLE;
      s_cnt_reg     <= 4'h0;
      s_sh_reg      <= 8'h00;
      s_tx_reg      <= 8'h00;
      s_sda_low_reg <= 1'b0;
      s_mack_reg    <= 1'b0;
      slv_addressed <= 1'b0;
      slv_read      <= 1'b0;
      slv_gc        <= 1'b0;
      slv_wake      <= 1'b0;
      slv_rx_data   <= 8'h00;
      slv_rx_valid  <= 1'b0;
      slv_tx_load   <= 1'b0;
    end
    else
    begin
      slv_addressed <= 1'b0;
      slv_wake      <= 1'b0;
      slv_rx_valid  <= 1'b0;
      slv_tx_load   <= 1'b0;
      if (stop_det || !slv_enable)
      begin
        s_state_reg   <= twbbl_pkg::S_IDLE;
        s_sda_low_reg <= 1'b0;
      end
      else if (start_det)
      begin
        // own master traffic is ignored
        s_state_reg   <= m_active ? twbbl_pkg::S_IDLE : twbbl_pkg::S_ADDR;
        s_cnt_reg     <= 4'h0;
        s_sda_low_reg <= 1'b0;
      end
      else if (s_state_reg != twbbl_pkg::S_IDLE)
      begin
        if (scl_rise)
        begin
          s_cnt_reg <= s_cnt_reg + 4'h1;
          if (s_cnt_reg < twbbl_pkg::LAST_DATA_BIT)
            s_sh_reg <= {s_sh_reg[6:0], sda_f_reg};
          else
            s_mack_reg <= ~sda_f_reg;
        end
        else if (scl_fall)
        begin
          if (s_cnt_reg == twbbl_pkg::LAST_DATA_BIT)
          begin
            s_sda_low_reg <= 1'b0;
            if (s_state_reg == twbbl_pkg::S_ADDR)
            begin
              if (addr_hit)
              begin
                s_sda_low_reg <= 1'b1;
                slv_addressed <= 1'b1;
                slv_wake      <= 1'b1;
                slv_read      <= s_sh_reg[0];
                slv_gc        <= gc_hit;
              end
              else
                s_state_reg <= twbbl_pkg::S_IDLE;
            end
            else if (s_state_reg == twbbl_pkg::S_RX)
            begin
              slv_rx_data   <= s_sh_reg;
              slv_rx_valid  <= 1'b1;
              s_sda_low_reg <= slv_ack_en;
            end
          end
          else if (s_cnt_reg == twbbl_pkg::ACK_BIT_RISE)
          begin
            s_cnt_reg <= 4'h0;
            if ((s_state_reg == twbbl_pkg::S_ADDR && slv_read)
                || (s_state_reg == twbbl_pkg::S_TX && s_mack_reg))
            begin
              s_tx_reg      <= {slv_tx_data[6:0], 1'b0};
              s_sda_low_reg <= ~slv_tx_data[7];
              slv_tx_load   <= 1'b1;
              s_state_reg   <= twbbl_pkg::S_TX;
            end
            else if (s_state_reg == twbbl_pkg::S_TX)
            begin
              // master nack: release
              s_sda_low_reg <= 1'b0;
              s_state_reg   <= twbbl_pkg::S_IDLE;
            end
            else
            begin
              s_sda_low_reg <= 1'b0;
              s_state_reg   <= twbbl_pkg::S_RX;
            end
          end
          else if (s_state_reg == twbbl_pkg::S_TX)
          begin
            s_sda_low_reg <= ~s_tx_reg[7];
            s_tx_reg      <= {s_tx_reg[6:0], 1'b0};
          end
        end
      end
    end
  end

  // ==========================================================
  // pin drivers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      scl_oe_n <= ~m_scl_low_reg;
      sda_oe_n <= ~(m_sda_low_reg | s_sda_low_reg);
    end
  end

  // a high is only a release
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

endmodule

// ### rtl/twbbl_pkg.sv
// constants and state types of the bus bit layer
package twbbl_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_FREQ_KHZ  = 400;
  // half serial period in clock cycles, rounded down by the integer division
  localparam int HALF_CYC_INT  = 1000000 / (2 * SCL_FREQ_KHZ * CLK_PERIOD_NS);
  localparam logic [4:0] HALF_CYC = HALF_CYC_INT[4:0];
  localparam int SPIKE_NS      = 50;
  localparam int SPIKE_CYC_INT = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SPIKE_CYC = SPIKE_CYC_INT[1:0];

  // ==========================================================
  // packet layout
  localparam int ADDR_W               = 7;
  localparam logic [6:0] GC_ADDR      = 7'h00;
  localparam logic [3:0] LAST_DATA_BIT = 4'h8;
  localparam logic [3:0] ACK_BIT_RISE = 4'h9;

  // ==========================================================
  // master commands
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ  = 2'h2;
  localparam logic [1:0] CMD_STOP  = 2'h3;

  // ==========================================================
  // state types
  typedef enum logic [3:0] {
    M_IDLE, M_START, M_HOLD, M_LOW, M_HIGH,
    M_STOP_LO, M_STOP_HI, M_STOP_END, M_RS_LO, M_RS_HI
  } twbbl_mstate_t;

  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_RX, S_TX} twbbl_sstate_t;

endpackage

// ### sim/twbbl_core_sva.sv
// assertions for the two-wire bus bit layer
`timescale 1ns/10ps
module twbbl_core_sva
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // handshake and events
  input wire logic cmd_ready,
  input wire logic slv_addressed,
  input wire logic slv_read,
  input wire logic slv_gc,
  input wire logic slv_wake,
  input wire logic bus_busy,
  input wire logic start_seen,
  input wire logic stop_seen
);
  // ==========================================================
  // helper state
  logic [5:0] low_cnt_reg;
  logic       foreign_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // saturates so a long stretch cannot wrap
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      low_cnt_reg <= 6'h00;
    else if (scl_oe_n)
      low_cnt_reg <= 6'h00;
    else if (low_cnt_reg != 6'h3F)
      low_cnt_reg <= low_cnt_reg + 6'h01;
  end
  // a foreign start owns the bus
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      foreign_reg <= 1'b0;
    else if (start_seen)
      foreign_reg <= sda_oe_n;
    else if (stop_seen)
      foreign_reg <= 1'b0;
  end
  // ==========================================================
  // checks
  drive_low_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("level not low");
  start_flag_a: assert property ($fell(sda_oe_n) && scl_in && $past(scl_in)
    && $past(sda_in) |-> ##[1:8] start_seen) else $error("start missed");
  stop_flag_a: assert property ($rose(sda_oe_n) && scl_in && $past(scl_in)
    && !$past(sda_in) |-> ##[1:8] stop_seen) else $error("stop missed");
  busy_set_a: assert property (start_seen |-> ##[0:1] bus_busy)
    else $error("busy not set");
  busy_clear_a: assert property (stop_seen |-> ##[0:1] !bus_busy)
    else $error("busy not clear");
  foreign_hold_a: assert property (foreign_reg && $past(foreign_reg) && !stop_seen
    |-> !cmd_ready) else $error("foreign accept");
  wake_pair_a: assert property (slv_wake == slv_addressed)
    else $error("wake unpaired");
  ack_drive_a: assert property (slv_addressed |-> ##[0:4] !sda_oe_n)
    else $error("no ack");
  gc_write_a: assert property (slv_addressed ##1 slv_gc |-> !slv_read)
    else $error("gc read");
  clk_low_a: assert property ($rose(scl_oe_n) |-> low_cnt_reg >= 6'h18)
    else $error("low too short");
endmodule

bind twbbl_core twbbl_core_sva chk
(
  .clk(clk), .reset(reset), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cmd_ready(cmd_ready),
  .slv_addressed(slv_addressed), .slv_read(slv_read), .slv_gc(slv_gc),
  .slv_wake(slv_wake), .bus_busy(bus_busy), .start_seen(start_seen), .stop_seen(stop_seen)
);

// ### sim/twbbl_core_tb.sv
// self-checking bench for the two-wire bus bit layer
`timescale 1ns/10ps
module twbbl_core_tb;
  localparam logic [6:0] P_ADDR = 7'h51;
  localparam logic [7:0] P_TX   = 8'h96;
  localparam logic [6:0] D_ADDR = 7'h2C;
  logic       clk, reset, scl_line, sda_line, p_scl_rel, p_sda_rel;
  logic       scl_out, scl_oe_n, sda_out, sda_oe_n, cmd_valid, cmd_ready, cmd_ack;
  logic       m_done, m_ack_rcvd, m_arb_lost, slv_enable, slv_gc_enable, slv_ack_en;
  logic       slv_addressed, slv_read, slv_gc, slv_wake, slv_rx_valid, slv_tx_load;
  logic       bus_busy, start_seen, stop_seen, k;
  logic [1:0] cmd_code;
  logic [6:0] slv_own_addr;
  logic [7:0] cmd_data, m_rd_data, slv_tx_data, slv_rx_data, rx_seen, q;
  int         bad_count = 0, samples_checked = 0, cycles = 0;
  int         n_start = 0, n_addr = 0, n_wake = 0, n;
  // wired-AND with pull-ups
  assign scl_line = (scl_oe_n ? 1'b1 : scl_out) & p_scl_rel;
  assign sda_line = (sda_oe_n ? 1'b1 : sda_out) & p_sda_rel;
  twbbl_core uut (.clk(clk), .reset(reset), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .cmd_ack(cmd_ack), .m_done(m_done), .m_rd_data(m_rd_data),
    .m_ack_rcvd(m_ack_rcvd), .m_arb_lost(m_arb_lost), .slv_enable(slv_enable),
    .slv_own_addr(slv_own_addr), .slv_gc_enable(slv_gc_enable), .slv_ack_en(slv_ack_en),
    .slv_tx_data(slv_tx_data), .slv_addressed(slv_addressed), .slv_read(slv_read),
    .slv_gc(slv_gc), .slv_wake(slv_wake), .slv_rx_data(slv_rx_data),
    .slv_rx_valid(slv_rx_valid), .slv_tx_load(slv_tx_load), .bus_busy(bus_busy),
    .start_seen(start_seen), .stop_seen(stop_seen));
  twbbl_partner #(.OWN_ADDR(P_ADDR), .TX_BYTE(P_TX)) partner (.scl(scl_line),
    .sda(sda_line), .scl_rel(p_scl_rel), .sda_rel(p_sda_rel));
  // ==========================================================
  // clock, event counters, hang guard
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk)
  begin
    if (start_seen === 1'b1)
      n_start++;
    if (slv_addressed === 1'b1)
      n_addr++;
    if (slv_wake === 1'b1)
      n_wake++;
    if (slv_rx_valid === 1'b1)
      rx_seen = slv_rx_data;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      stop_test();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hold request until taken, then await done
  task automatic do_cmd(input logic [1:0] c, input logic [7:0] d, input logic a);
    cmd_code  = c;
    cmd_data  = d;
    cmd_ack   = a;
    cmd_valid = 1'b1;
    for (n = 0; n < 4000 && cmd_ready !== 1'b1; n++)
      @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 4000 && m_done !== 1'b1; n++)
      @(negedge clk);
    chk_bit("done", 1'b1, m_done);
  endtask
  task automatic bus_idle;
    for (n = 0; n < 40 && bus_busy !== 1'b0; n++)
      @(negedge clk);
    chk_bit("bus idle", 1'b0, bus_busy);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_master;
    do_cmd(twbbl_pkg::CMD_START, 8'h00, 1'b0);
    chk_bit("busy", 1'b1, bus_busy);
    do_cmd(twbbl_pkg::CMD_WRITE, {P_ADDR, 1'b0}, 1'b0);
    chk_bit("addr ack", 1'b1, m_ack_rcvd);
    chk_byte("readback", {P_ADDR, 1'b0}, m_rd_data);
    do_cmd(twbbl_pkg::CMD_WRITE, 8'hA5, 1'b0);
    chk_byte("far byte", 8'hA5, partner.rx_byte);
    do_cmd(twbbl_pkg::CMD_START, 8'h00, 1'b0);
    chk_bit("busy rs", 1'b1, bus_busy);
    do_cmd(twbbl_pkg::CMD_WRITE, {P_ADDR, 1'b1}, 1'b0);
    chk_bit("rd addr ack", 1'b1, m_ack_rcvd);
    do_cmd(twbbl_pkg::CMD_READ, 8'h00, 1'b0);
    chk_byte("read byte", P_TX, m_rd_data);
    do_cmd(twbbl_pkg::CMD_STOP, 8'h00, 1'b0);
    bus_idle();
    do_cmd(twbbl_pkg::CMD_START, 8'h00, 1'b0);
    do_cmd(twbbl_pkg::CMD_WRITE, 8'h66, 1'b0);
    chk_bit("nack", 1'b0, m_ack_rcvd);
    do_cmd(twbbl_pkg::CMD_STOP, 8'h00, 1'b0);
    bus_idle();
    $display("master test done");
  endtask
  task automatic t_slave;
    int a0;
    a0 = n_addr;
    partner.m_start();
    partner.m_byte({D_ADDR, 1'b0}, 1'b1, q, k);
    @(negedge clk);
    chk_bit("own ack", 1'b0, k);
    chk_bit("foreign ready", 1'b0, cmd_ready);
    partner.m_byte(8'h3C, 1'b1, q, k);
    chk_bit("data ack", 1'b0, k);
    partner.m_stop();
    @(negedge clk);
    chk_byte("slave rx", 8'h3C, rx_seen);
    chk_bit("one match", 1'b1, n_addr == a0 + 1);
    chk_bit("wake", 1'b1, n_wake == a0 + 1);
    chk_bit("write flag", 1'b0, slv_read);
    bus_idle();
    partner.m_start();
    partner.m_byte({D_ADDR, 1'b1}, 1'b1, q, k);
    partner.m_byte(8'hFF, 1'b1, q, k);
    partner.m_stop();
    @(negedge clk);
    chk_byte("slave tx", 8'h5A, q);
    chk_bit("read flag", 1'b1, slv_read);
    $display("slave test done");
  endtask
  task automatic t_gc_spike;
    int s0;
    for (int g = 0; g < 2; g++)
    begin
      slv_gc_enable = g[0];
      partner.m_start();
      partner.m_byte({7'h00, 1'b0}, 1'b1, q, k);
      partner.m_stop();
      @(negedge clk);
      chk_bit("gc ack", ~g[0], k);
    end
    chk_bit("gc flag", 1'b1, slv_gc);
    s0 = n_start;
    partner.spike();
    repeat (10) @(negedge clk);
    chk_bit("spike ignored", 1'b1, n_start == s0);
    chk_bit("spike no busy", 1'b0, bus_busy);
    $display("gc spike test done");
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    reset         = 1'b1;
    cmd_valid     = 1'b0;
    cmd_code      = 2'h0;
    cmd_data      = 8'h00;
    cmd_ack       = 1'b0;
    slv_enable    = 1'b1;
    slv_own_addr  = D_ADDR;
    slv_gc_enable = 1'b0;
    slv_ack_en    = 1'b1;
    slv_tx_data   = 8'h5A;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    chk_bit("scl free", 1'b1, scl_oe_n);
    chk_bit("sda free", 1'b1, sda_oe_n);
    chk_bit("ready", 1'b1, cmd_ready);
    t_master();
    t_slave();
    t_gc_spike();
    stop_test();
  end
endmodule

// ### sim/twbbl_partner.sv
// far-side model: answering slave and task-driven master
`timescale 1ns/10ps
module twbbl_partner
#(
  parameter logic [6:0] OWN_ADDR = 7'h51,
  parameter logic [7:0] TX_BYTE  = 8'h96
)
(
  // resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // releases, high lets the pull-up win
  output logic     scl_rel,
  output logic     sda_rel
);
  logic [7:0] rx_byte;
  logic       mst_on;
  initial
  begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    rx_byte = 8'h00;
    mst_on  = 1'b0;
  end
  // ==========================================================
  // slave side
  // r: 0/1 data bit, 2 start, 3 stop (data moved while clock high)
  task automatic get_bit(output int r);
    @(posedge scl);
    r = int'(sda);
    @(negedge scl or sda);
    if (scl === 1'b1)
      r = (sda === 1'b1) ? 3 : 2;
  endtask
  task automatic slave_frame;
    logic [7:0] b;
    int         r;
    logic       first;
    logic       rd;
    first = 1'b1;
    rd    = 1'b0;
    b     = 8'h00;
    forever
    begin
      if (rd)
      begin
        for (int i = 7; i >= 0; i--)
        begin
          #100 sda_rel = TX_BYTE[i];
          @(negedge scl);
        end
        #100 sda_rel = 1'b1;
        get_bit(r);
        if (r != 0)
          return;
      end
      else
      begin
        for (int i = 7; i >= 0; i--)
        begin
          get_bit(r);
          if (r == 3)
            return;
          if (r == 2)
          begin
            first = 1'b1;
            i     = 8;
          end
          else
            b[i] = r[0];
        end
        if (first && b[7:1] != OWN_ADDR)
          return;
        if (!first)
          rx_byte = b;
        rd    = first & b[0];
        first = 1'b0;
        #100 sda_rel = 1'b0;
        @(negedge scl);
        #100 sda_rel = 1'b1;
      end
    end
  endtask
  initial
  begin
    forever
    begin
      @(negedge sda iff (scl === 1'b1 && !mst_on));
      slave_frame();
    end
  end
  // ==========================================================
  // master side, 1600 ns bit: the filtered slave needs 300 ns to answer a fall
  task automatic m_bit(input logic v, output logic s);
    #300 sda_rel = v;
    #500 scl_rel = 1'b1;
    wait (scl === 1'b1);
    #400 s = sda;
    #400 scl_rel = 1'b0;
  endtask
  task automatic m_start;
    mst_on  = 1'b1;
    sda_rel = 1'b0;
    #200 scl_rel = 1'b0;
  endtask
  task automatic m_byte(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic k);
    for (int i = 7; i >= 0; i--)
      m_bit(d[i], q[i]);
    m_bit(a, k);
  endtask
  task automatic m_stop;
    #300 sda_rel = 1'b0;
    #500 scl_rel = 1'b1;
    #400 sda_rel = 1'b1;
    #400 mst_on = 1'b0;
  endtask
  // sub-clock dip with clock high
  task automatic spike;
    mst_on = 1'b1;
    #100 sda_rel = 1'b0;
    #40 sda_rel = 1'b1;
    #200 mst_on = 1'b0;
  endtask
endmodule
